// >>> pkg/fifo_wp_pkg.sv
/*
 * Shared constants for the write side of the 1024 x 18 clocked FIFO:
 * widths, flag levels, reset edge counts, register map and event bits.
 * Assumes one 125 MHz system clock; FIFO pins are sampled on it.
 */
package fifo_wp_pkg;

	localparam int unsigned WORD_W = 18;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned PTR_W  = 11;
	localparam int unsigned OFF_W  = 9;
	localparam int unsigned EV_W   = 5;
	localparam int unsigned SY_W   = 24;

	localparam logic [PTR_W-1:0] FULL_COUNT = 11'h400;
	localparam logic [PTR_W-1:0] HALF_COUNT = 11'h200;
	localparam logic [PTR_W-1:0] PTR_ONE    = 11'h001;
	localparam logic [OFF_W-1:0] DEF_OFFSET = 9'h100;

	// Write/read clock edges seen while reset is held
	localparam logic [2:0] RESET_EDGES = 3'h4;
	localparam logic [2:0] EDGE_ONE    = 3'h1;

	// Bit positions in the sampled pin vector
	localparam int unsigned SY_WCLK = 18;
	localparam int unsigned SY_RCLK = 19;
	localparam int unsigned SY_ENA  = 20;
	localparam int unsigned SY_ENB  = 21;
	localparam int unsigned SY_SEL  = 22;
	localparam int unsigned SY_RST  = 23;

	// Register word indices (byte address = 4 * index)
	localparam logic [2:0] IDX_STATUS = 3'h0;
	localparam logic [2:0] IDX_MASK   = 3'h1;
	localparam logic [2:0] IDX_LEVEL  = 3'h2;
	localparam logic [2:0] IDX_OFFSET = 3'h3;
	localparam logic [2:0] IDX_DATA   = 3'h4;
	localparam int unsigned IDX_LSB   = 2;
	localparam int unsigned IDX_MSB   = 4;
	localparam int unsigned HI_LSB    = 5;

	// Event bits of status and mask
	localparam int unsigned EV_WORD  = 0;
	localparam int unsigned EV_FULL  = 1;
	localparam int unsigned EV_OFF   = 2;
	localparam int unsigned EV_RST   = 3;
	localparam int unsigned EV_UNDER = 4;

	// Level and offset register fields
	localparam int unsigned LV_RDY  = 16;
	localparam int unsigned LV_OR   = 17;
	localparam int unsigned LV_HALF = 18;
	localparam int unsigned LV_AL   = 19;
	localparam int unsigned CAP_LSB = 16;

	typedef enum logic [3:0] {
		ST_POWERUP = 4'h1,
		ST_RESET   = 4'h2,
		ST_WAKE    = 4'h4,
		ST_RUN     = 4'h8
	} phase_t;

endpackage

// >>> hw/fifo_word_mem.sv
/*
 * Word store of the FIFO, 1024 x 18, one write and one read port.
 * Read data come out of a register one edge after the address.
 * Same-edge read of a word being written returns the old word.
 */
`timescale 1ns/1ps
module fifo_word_mem
	import fifo_wp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [WORD_W-1:0] wrData,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [WORD_W-1:0] rdData
);

	logic [WORD_W-1:0] words [0:(1<<ADDR_W)-1];

	// No reset on the array; contents are invalid until written
	always_ff @(posedge clk) begin
		if (wrEn) begin
			words[wrAddr] <= wrData;
		end
		rdData <= words[rdAddr];
	end

endmodule

// >>> hw/fifo_write_port.sv
/*
 * Write side of the clocked FIFO: pin sampling, word storage,
 * input-ready timing, the two-clock reset sequence, offset select,
 * flags, and an AHB-Lite register slave with a pop port.
 * Assumes FIFO pins are slow against clk and held steady a few clocks.
 */
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module fifo_write_port
	import fifo_wp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              writeSideClock,
	input  wire logic              readSideClock,
	input  wire logic              writeEnableA,
	input  wire logic              writeEnableB,
	input  wire logic              offsetSelectN,
	input  wire logic              fifoResetN,
	input  wire logic [WORD_W-1:0] dataInBus,
	output logic                   inputReadyFlag,
	output logic                   outputReadyFlag,
	output logic                   halfLevelFlag,
	output logic                   almostLevelFlag,
	output logic                   irq,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [31:0]       hrdata
);

	typedef struct packed {
		phase_t           mode;
		logic [SY_W-1:0]  sA;
		logic [SY_W-1:0]  sB;
		logic [SY_W-1:0]  sC;
		logic [SY_W-1:0]  filt;
		logic [PTR_W-1:0] wrPtr;
		logic [PTR_W-1:0] rdPtr;
		logic [PTR_W-1:0] wrSeen;
		logic [2:0]       wEdges;
		logic [2:0]       rEdges;
		logic             done;
		logic             inReady;
		logic             outReady;
		logic             halfFlag;
		logic             almostFlag;
		logic [OFF_W-1:0] capOff;
		logic [OFF_W-1:0] actOff;
		logic [EV_W-1:0]  status;
		logic [EV_W-1:0]  mask;
		logic             apValid;
		logic             apWrite;
		logic             apHit;
		logic [2:0]       apIdx;
		logic [31:0]      rdata;
	} port_state_t;

	localparam port_state_t S_INIT = '{mode: ST_POWERUP, default: '0};

	port_state_t       s_reg;
	port_state_t       s_next;
	logic [SY_W-1:0]   pinVec;
	logic [SY_W-1:0]   agree;
	logic [SY_W-1:0]   riseV;
	logic [SY_W-1:0]   fallV;
	logic              wRise;
	logic              rRise;
	logic              selFall;
	logic              rstFall;
	logic              rstRise;
	logic              storeCond;
	logic [PTR_W-1:0]  count;
	logic [PTR_W-1:0]  avail;
	logic              accept;
	logic              mapped;
	logic [2:0]        aIdx;
	logic              memWe;
	logic [ADDR_W-1:0] memRdAddr;
	logic [WORD_W-1:0] memRdData;
	logic [EV_W-1:0]   evSet;
	logic [EV_W-1:0]   evClr;

	// Pins gathered so one three-stage sampler serves all of them
	assign pinVec = {fifoResetN, offsetSelectN, writeEnableB, writeEnableA,
		readSideClock, writeSideClock, dataInBus};

	// A level counts once stages two and three agree; stage one feeds only stage two
	assign agree = ~(s_reg.sB ^ s_reg.sC);
	assign riseV = agree & s_reg.sB & ~s_reg.filt;
	assign fallV = agree & ~s_reg.sB & s_reg.filt;

	// Edges of the free-running write clock and the other pins
	assign wRise   = riseV[SY_WCLK];
	assign rRise   = riseV[SY_RCLK];
	assign selFall = fallV[SY_SEL];
	assign rstFall = fallV[SY_RST];
	assign rstRise = riseV[SY_RST];

	// Word is taken only with ready and both enables high
	assign storeCond = wRise && s_reg.inReady && s_reg.filt[SY_ENA] && s_reg.filt[SY_ENB];

	// Occupancy; avail lags one clock so a fresh word is never read stale
	assign count = s_reg.wrPtr - s_reg.rdPtr;
	assign avail = s_reg.wrSeen - s_reg.rdPtr;

	// Bus address phase decode
	assign accept = hsel && htrans[1] && hready;
	assign aIdx   = haddr[IDX_MSB:IDX_LSB];
	assign mapped = (haddr[31:HI_LSB] == '0) && (aIdx <= IDX_DATA);

	always_comb begin
		s_next    = s_reg;
		memWe     = 1'b0;
		memRdAddr = s_reg.rdPtr[ADDR_W-1:0];
		evSet     = '0;
		evClr     = '0;
		// Sampler stages and filtered levels
		s_next.sA     = pinVec;
		s_next.sB     = s_reg.sA;
		s_next.sC     = s_reg.sB;
		s_next.filt   = (agree & s_reg.sB) | (~agree & s_reg.filt);
		s_next.wrSeen = s_reg.wrPtr;
		// Offset taken on select fall, enables play no part
		if (selFall) begin
			s_next.capOff = s_reg.filt[OFF_W-1:0];
			evSet[EV_OFF] = 1'b1;
		end
		// Bus address phase: register read data, data port pops
		s_next.apValid = accept;
		s_next.apWrite = hwrite;
		s_next.apHit   = mapped;
		s_next.apIdx   = aIdx;
		if (accept && !hwrite) begin
			s_next.rdata = '0;
			if (mapped) begin
				case (aIdx)
					IDX_STATUS: begin
						s_next.rdata[EV_W-1:0] = s_reg.status;
					end
					IDX_MASK: begin
						s_next.rdata[EV_W-1:0] = s_reg.mask;
					end
					IDX_LEVEL: begin
						s_next.rdata[PTR_W-1:0] = count;
						s_next.rdata[LV_RDY]    = s_reg.inReady;
						s_next.rdata[LV_OR]     = s_reg.outReady;
						s_next.rdata[LV_HALF]   = s_reg.halfFlag;
						s_next.rdata[LV_AL]     = s_reg.almostFlag;
					end
					IDX_OFFSET: begin
						s_next.rdata[OFF_W-1:0]          = s_reg.actOff;
						s_next.rdata[CAP_LSB +: OFF_W]   = s_reg.capOff;
					end
					IDX_DATA: begin
						s_next.rdata[WORD_W-1:0] = memRdData;
						if (s_reg.mode == ST_RUN && avail != '0) begin
							s_next.rdPtr = s_reg.rdPtr + PTR_ONE;
						end else begin
							evSet[EV_UNDER] = 1'b1;
						end
					end
					default: begin
						s_next.rdata = '0;
					end
				endcase
			end
		end
		// Bus data phase of a write
		if (s_reg.apValid && s_reg.apWrite && s_reg.apHit) begin
			if (s_reg.apIdx == IDX_STATUS) begin
				evClr = hwdata[EV_W-1:0];
			end else if (s_reg.apIdx == IDX_MASK) begin
				s_next.mask = hwdata[EV_W-1:0];
			end
		end
		// Reset pin fall restarts the sequence from any phase
		if (rstFall) begin
			s_next.mode   = ST_RESET;
			s_next.wEdges = '0;
			s_next.rEdges = '0;
			s_next.done   = 1'b0;
		end else begin
			case (s_reg.mode)
				ST_POWERUP: begin
					// Nothing works until a full reset; ready still drops only on a write edge
					s_next.inReady = s_reg.inReady && !wRise;
					if (!s_reg.filt[SY_RST]) begin
						s_next.mode   = ST_RESET;
						s_next.wEdges = '0;
						s_next.rEdges = '0;
					end
				end
				ST_RESET: begin
					if (wRise && s_reg.wEdges < RESET_EDGES) begin
						s_next.wEdges = s_reg.wEdges + EDGE_ONE;
						if (s_reg.wEdges == EDGE_ONE) begin
							s_next.inReady = 1'b0;
						end
					end
					if (rRise && s_reg.rEdges < RESET_EDGES) begin
						s_next.rEdges = s_reg.rEdges + EDGE_ONE;
					end
					// Four edges of each clock complete the reset
					if (!s_reg.done && s_reg.wEdges >= RESET_EDGES && s_reg.rEdges >= RESET_EDGES) begin
						s_next.done       = 1'b1;
						s_next.wrPtr      = '0;
						s_next.rdPtr      = '0;
						s_next.wrSeen     = '0;
						s_next.inReady    = 1'b0;
						s_next.outReady   = 1'b0;
						s_next.halfFlag   = 1'b0;
						s_next.almostFlag = 1'b1;
						evSet[EV_RST]     = 1'b1;
					end
					// Release: select level picks the offset source
					if (rstRise) begin
						if (s_reg.done) begin
							s_next.mode   = ST_WAKE;
							s_next.wEdges = '0;
							if (s_reg.filt[SY_SEL]) begin
								s_next.actOff = DEF_OFFSET;
							end else begin
								s_next.actOff = s_reg.capOff;
							end
						end else begin
							// Short reset is not honoured
							s_next.mode = ST_POWERUP;
						end
					end
				end
				ST_WAKE: begin
					// Ready rises on the second write edge after release
					if (wRise) begin
						s_next.wEdges = s_reg.wEdges + EDGE_ONE;
						if (s_reg.wEdges == EDGE_ONE) begin
							s_next.inReady = 1'b1;
							s_next.mode    = ST_RUN;
						end
					end
				end
				ST_RUN: begin
					if (storeCond) begin
						memWe          = 1'b1;
						s_next.wrPtr   = s_reg.wrPtr + PTR_ONE;
						evSet[EV_WORD] = 1'b1;
						if (count + PTR_ONE == FULL_COUNT) begin
							evSet[EV_FULL] = 1'b1;
						end
					end
					// Ready follows fullness, but only at write edges
					if (wRise) begin
						s_next.inReady = storeCond ? (count + PTR_ONE) != FULL_COUNT : count != FULL_COUNT;
					end
					// Level flags; only the almost flag uses the programmed offset
					s_next.outReady   = avail != '0;
					s_next.halfFlag   = count > HALF_COUNT;
					s_next.almostFlag = (count <= {2'h0, s_reg.actOff})
						|| (count >= FULL_COUNT - {2'h0, s_reg.actOff});
				end
				default: begin
					s_next.mode = ST_POWERUP;
				end
			endcase
		end

		// Sticky events; a new event beats a same-cycle clear
		s_next.status = (s_reg.status & ~evClr) | evSet;
		memRdAddr     = s_next.rdPtr[ADDR_W-1:0];
	end

	// All state in one register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= S_INIT;
		end else begin
			s_reg <= s_next;
		end
	end

	fifo_word_mem u_mem (
		.clk    (clk),
		.wrEn   (memWe),
		.wrAddr (s_reg.wrPtr[ADDR_W-1:0]),
		.wrData (s_reg.filt[WORD_W-1:0]),
		.rdAddr (memRdAddr),
		.rdData (memRdData)
	);

	// Outputs; slave never stalls and always answers OKAY
	assign inputReadyFlag  = s_reg.inReady;
	assign outputReadyFlag = s_reg.outReady;
	assign halfLevelFlag   = s_reg.halfFlag;
	assign almostLevelFlag = s_reg.almostFlag;
	assign irq             = |(s_reg.status & s_reg.mask);
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign hrdata          = s_reg.rdata;

	// Checks on the sequencing above
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_bothCounted;
		s_reg.mode == ST_RESET && !s_reg.done
			&& s_reg.wEdges >= RESET_EDGES && s_reg.rEdges >= RESET_EDGES;
	endsequence
	sequence s_cleared;
		s_reg.wrPtr == '0 && s_reg.rdPtr == '0 && !s_reg.halfFlag
			&& s_reg.almostFlag && !s_reg.inReady && s_reg.done;
	endsequence
	sequence s_releaseArmed;
		s_reg.mode == ST_WAKE && !rstFall && wRise && s_reg.wEdges == EDGE_ONE;
	endsequence
	sequence s_doneRelease;
		s_reg.mode == ST_RESET && !rstFall && rstRise && s_reg.done;
	endsequence
	property p_store;
		s_reg.mode == ST_RUN && !rstFall && storeCond
			|=> s_reg.wrPtr == $past(s_reg.wrPtr) + PTR_ONE;
	endproperty
	a_store: assert property (p_store) else $error("word not stored");
	property p_noStore;
		s_reg.mode == ST_RUN && !rstFall && !storeCond |=> $stable(s_reg.wrPtr);
	endproperty
	a_noStore: assert property (p_noStore) else $error("word stored without qualification");
	// Ready is already low when reset completes, so every change follows a write edge
	property p_readySync;
		$changed(s_reg.inReady) |-> $past(wRise);
	endproperty
	a_readySync: assert property (p_readySync) else $error("ready changed off a write edge");
	property p_capAnyEnable;
		selFall && !s_reg.filt[SY_ENA] |=> s_reg.capOff == $past(s_reg.filt[OFF_W-1:0]);
	endproperty
	a_capAnyEnable: assert property (p_capAnyEnable) else $error("offset blocked by enable");
	property p_capture;
		selFall |=> s_reg.capOff == $past(s_reg.filt[OFF_W-1:0]) && s_reg.status[EV_OFF];
	endproperty
	a_capture: assert property (p_capture) else $error("offset not captured");
	property p_userOffset;
		s_doneRelease and !s_reg.filt[SY_SEL]
			|=> s_reg.actOff == $past(s_reg.capOff) && s_reg.mode == ST_WAKE;
	endproperty
	a_userOffset: assert property (p_userOffset) else $error("captured offset not applied");
	property p_defaultOffset;
		s_doneRelease and s_reg.filt[SY_SEL] |=> s_reg.actOff == DEF_OFFSET;
	endproperty
	a_defaultOffset: assert property (p_defaultOffset) else $error("default offset not applied");
	property p_resetDone;
		s_bothCounted and !rstFall and !rstRise |=> s_cleared;
	endproperty
	a_resetDone: assert property (p_resetDone) else $error("reset did not clear state");
	property p_readyLowInReset;
		s_reg.mode == ST_RESET && !rstFall && wRise && s_reg.wEdges == EDGE_ONE |=> !s_reg.inReady;
	endproperty
	a_readyLowInReset: assert property (p_readyLowInReset) else $error("ready not low in reset");
	property p_readyWake;
		s_releaseArmed |=> s_reg.inReady && s_reg.mode == ST_RUN;
	endproperty
	a_readyWake: assert property (p_readyWake) else $error("ready not raised after release");

endmodule

// >>> tb/fifo_writer_model.sv
/*
 * Model of the system logic that writes into the FIFO: free-running write
 * and read clocks, enables, data, offset select and FIFO reset.
 * Assumes every task is called from one testbench process, after a clk edge.
 */
`timescale 1ns/1ps
module fifo_writer_model
	import fifo_wp_pkg::*;
#(
	parameter int WR_HALF = 6,
	parameter int RD_HALF = 7
)
(
	input  wire logic              clk,
	output logic                   writeSideClock,
	output logic                   readSideClock,
	output logic                   writeEnableA,
	output logic                   writeEnableB,
	output logic                   offsetSelectN,
	output logic                   fifoResetN,
	output logic      [WORD_W-1:0] dataInBus
);
	int wrCnt = 0;
	int rdCnt = 0;
	int rises = 0;

	// Idle pins; reset is low before any clock rise
	initial begin
		writeSideClock = 1'b0;
		readSideClock  = 1'b0;
		writeEnableA   = 1'b0;
		writeEnableB   = 1'b0;
		offsetSelectN  = 1'b1;
		fifoResetN     = 1'b0;
		dataInBus      = 18'h00000;
	end

	// Clocks never pause, slow against clk so each phase gets sampled
	always @(posedge clk) begin
		wrCnt <= (wrCnt == WR_HALF - 1) ? 0 : wrCnt + 1;
		rdCnt <= (rdCnt == RD_HALF - 1) ? 0 : rdCnt + 1;
		if (wrCnt == WR_HALF - 1) begin
			writeSideClock <= ~writeSideClock;
			rises          <= rises + int'(!writeSideClock);
		end
		if (rdCnt == RD_HALF - 1) begin
			readSideClock <= ~readSideClock;
		end
	end

	// Returns one clk after the n-th write-clock rise from now
	task automatic waitRise(input int n);
		int s;
		s = rises;
		while (rises < s + n) begin
			@(posedge clk);
		end
	endtask

	// Word and enables set up a full period ahead, held to the falling edge
	task automatic writeWord(input logic [WORD_W-1:0] d, input logic a, input logic b);
		waitRise(1);
		dataInBus    <= d;
		writeEnableA <= a;
		writeEnableB <= b;
		waitRise(1);
		repeat (WR_HALF - 1) @(posedge clk);
		dataInBus    <= ~d; // Bus no longer shows the word once hold ends
		writeEnableA <= 1'b0;
		writeEnableB <= 1'b0;
	endtask

	// Offset value stands on the bus well before and after select moves
	task automatic selectOffset(input logic [WORD_W-1:0] d, input logic lvl);
		@(posedge clk);
		dataInBus <= d;
		repeat (WR_HALF) @(posedge clk);
		offsetSelectN <= lvl;
		repeat (WR_HALF) @(posedge clk);
		dataInBus <= ~d;
	endtask
endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking testbench of the FIFO write port: FIFO reset timing, word
 * storage, offset select and the register slave over AHB-Lite.
 * Assumes the writer model drives all FIFO pins from clk edges.
 */
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        resetn;
	logic        wClk, rClk, enA, enB, selN, fResetN;
	logic [17:0] dataBus;
	logic        inputReadyFlag, outputReadyFlag, halfLevelFlag, almostLevelFlag, irq;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;

	fifo_writer_model pw (.clk(clk), .writeSideClock(wClk), .readSideClock(rClk), .writeEnableA(enA),
		.writeEnableB(enB), .offsetSelectN(selN), .fifoResetN(fResetN), .dataInBus(dataBus));

	fifo_write_port dut (.clk(clk), .resetn(resetn), .writeSideClock(wClk), .readSideClock(rClk),
		.writeEnableA(enA), .writeEnableB(enB), .offsetSelectN(selN), .fifoResetN(fResetN),
		.dataInBus(dataBus), .inputReadyFlag(inputReadyFlag), .outputReadyFlag(outputReadyFlag),
		.halfLevelFlag(halfLevelFlag), .almostLevelFlag(almostLevelFlag), .irq(irq), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

	// 125 MHz clock
	always #4 clk = ~clk;

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Sample at the falling edge so register updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Single word transfer; address phase held until hready, then data phase
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= 3'h2;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		hsize  <= 3'h0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	// Reset released at a write-clock fall, half a period from either rise, so no write edge races the release
	task automatic fifoReset(input logic expRdy);
		pw.waitRise(1);
		repeat (5) @(posedge clk);
		pw.fifoResetN <= 1'b0;
		pw.waitRise(1);
		settle(5);
		check({31'h0, inputReadyFlag}, {31'h0, expRdy});
		pw.waitRise(1);
		settle(5);
		check({31'h0, inputReadyFlag}, 32'h0);
		pw.waitRise(4);
		repeat (5) @(posedge clk);
		pw.fifoResetN <= 1'b1;
		settle(1);
		check({28'h0, almostLevelFlag, halfLevelFlag, outputReadyFlag, inputReadyFlag}, 32'h8);
		pw.waitRise(1);
		settle(5);
		check({31'h0, inputReadyFlag}, 32'h0);
		pw.waitRise(1);
		settle(5);
		check({31'h0, inputReadyFlag}, 32'h1);
	endtask

	// Select high across release picks the default offset
	task automatic defaultOffset();
		logic [31:0] v;
		ahb(1'b0, 32'hc, 32'h0, v);
		check({23'h0, v[8:0]}, 32'h100);
		ahb(1'b0, 32'h8, 32'h0, v);
		check({21'h0, v[10:0]}, 32'h0);
	endtask

	// Every enable combination; only both high stores a word
	task automatic writeGate();
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			pw.writeWord(18'h2a5c3 ^ 18'(i), i[0], i[1]);
		end
		settle(2);
		ahb(1'b0, 32'h8, 32'h0, v);
		check({21'h0, v[10:0]}, 32'h1);
		check({31'h0, outputReadyFlag}, 32'h1);
		ahb(1'b0, 32'h10, 32'h0, v);
		check({14'h0, v[17:0]}, 32'h2a5c0);
	endtask

	// Word event raises irq only while unmasked; write-one clears it
	task automatic irqPath();
		logic [31:0] v;
		ahb(1'b1, 32'h0, 32'h1f, v);
		ahb(1'b1, 32'h4, 32'h0, v);
		pw.writeWord(18'h00111, 1'b1, 1'b1);
		settle(2);
		check({31'h0, irq}, 32'h0);
		ahb(1'b1, 32'h4, 32'h1, v);
		settle(1);
		check({31'h0, irq}, 32'h1);
		ahb(1'b1, 32'h0, 32'h1, v);
		settle(1);
		check({31'h0, irq}, 32'h0);
		ahb(1'b1, 32'h4, 32'h0, v);
	endtask

	// Upper data bits set to show only the low nine are taken
	task automatic offsetProgram();
		logic [31:0] v;
		pw.selectOffset(18'h3fd5a, 1'b0);
		settle(1);
		ahb(1'b0, 32'hc, 32'h0, v);
		check({23'h0, v[24:16]}, 32'h15a);
		fifoReset(1'b1);
		ahb(1'b0, 32'hc, 32'h0, v);
		check({23'h0, v[8:0]}, 32'h15a);
		ahb(1'b0, 32'h0, 32'h0, v);
		check({30'h0, v[3:2]}, 32'h3);
		pw.selectOffset(18'h3fd5a, 1'b1);
	endtask

	// Unmapped place reads zero and ignores writes; a pop while empty flags underflow
	task automatic unmapped();
		logic [31:0] v;
		ahb(1'b1, 32'h14, 32'hffffffff, v);
		ahb(1'b0, 32'h14, 32'h0, v);
		check(v, 32'h0);
		ahb(1'b0, 32'h10, 32'h0, v);
		ahb(1'b0, 32'h0, 32'h0, v);
		check({31'h0, v[4]}, 32'h1);
	endtask

	// Main sequence
	initial begin
		logic [31:0] v;
		resetn = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h0;
		hwdata = 32'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		ahb(1'b0, 32'h4, 32'h0, v);
		check(v, 32'h0);
		fifoReset(1'b0);
		defaultOffset();
		writeGate();
		irqPath();
		offsetProgram();
		unmapped();
		results();
	end
endmodule
